/* logic/audio_adc_ctrl_pkg.sv */
// Package: control word, register layouts, reset values and decoded settings
package audio_adc_ctrl_pkg;

  // ==========================================================================
  // Control word and register addresses
  // ==========================================================================
  localparam int         ADDR_W               = 7;
  localparam int         DATA_W               = 9;
  localparam logic [6:0] ZC_TIMEOUT_ADDR      = 7'h07;
  localparam logic [6:0] AUDIO_INTERFACE_ADDR = 7'h0B;
  localparam logic [6:0] MASTER_CLOCKING_ADDR = 7'h0C;
  localparam logic [6:0] POWER_DOWN_ADDR      = 7'h0D;
  localparam logic [6:0] LEFT_GAIN_ADDR       = 7'h0E;
  localparam logic [6:0] RIGHT_GAIN_ADDR      = 7'h0F;
  localparam logic [6:0] LEVEL_ONE_ADDR       = 7'h10;
  localparam logic [6:0] LEVEL_TWO_ADDR       = 7'h11;
  localparam logic [6:0] LEVEL_RATES_ADDR     = 7'h12;
  localparam logic [6:0] QUIET_GATE_ADDR      = 7'h13;
  localparam logic [6:0] LIMITER_WINDOW_ADDR  = 7'h14;
  localparam logic [6:0] INPUT_SELECT_ADDR    = 7'h15;
  localparam logic [6:0] SOFTWARE_RESET_ADDR  = 7'h17;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [8:0]  ZC_TIMEOUT_RESET      = 9'h000;
  localparam logic [8:0]  AUDIO_INTERFACE_RESET = 9'h022;
  localparam logic [8:0]  MASTER_CLOCKING_RESET = 9'h022;
  // Only the low nine bits of the printed default reach the register
  localparam logic [11:0] POWER_DOWN_RESET_RAW  = 12'h800;
  localparam logic [8:0]  POWER_DOWN_RESET      = POWER_DOWN_RESET_RAW[8:0];
  localparam logic [8:0]  GAIN_RESET            = 9'h0CF;
  localparam logic [7:0]  GAIN_ZERO_DB          = 8'hCF;
  localparam logic [8:0]  LEVEL_ONE_RESET       = 9'h07B;
  localparam logic [8:0]  LEVEL_TWO_RESET       = 9'h000;
  localparam logic [8:0]  LEVEL_RATES_RESET     = 9'h032;
  localparam logic [8:0]  QUIET_GATE_RESET      = 9'h000;
  localparam logic [8:0]  LIMITER_WINDOW_RESET  = 9'h0A6;
  localparam logic [8:0]  INPUT_SELECT_RESET    = 9'h001;

  // ==========================================================================
  // Codes and decoded figures
  // ==========================================================================
  typedef enum logic [1:0] {
    FMT_RIGHT_JUST = 2'b00,
    FMT_LEFT_JUST  = 2'b01,
    FMT_I2S        = 2'b10,
    FMT_DSP        = 2'b11
  } framing_t;

  typedef enum logic [1:0] {
    WL_16   = 2'b00,
    WL_20   = 2'b01,
    WL_24   = 2'b10,
    WL_RSVD = 2'b11
  } word_len_t;

  typedef enum logic [1:0] {
    LF_LIMITER = 2'b00,
    LF_RIGHT   = 2'b01,
    LF_LEFT    = 2'b10,
    LF_STEREO  = 2'b11
  } level_fn_t;

  localparam logic [2:0] RATE_256 = 3'h2;
  localparam logic [2:0] RATE_384 = 3'h3;
  localparam logic [2:0] RATE_512 = 3'h4;
  localparam logic [2:0] RATE_768 = 3'h5;
  localparam logic [9:0] MCLK_256 = 10'h100;
  localparam logic [9:0] MCLK_384 = 10'h180;
  localparam logic [9:0] MCLK_512 = 10'h200;
  localparam logic [9:0] MCLK_768 = 10'h300;
  localparam logic [7:0] OSR_128  = 8'h80;
  localparam logic [7:0] OSR_64   = 8'h40;
  localparam logic [5:0] BITS_16  = 6'h10;
  localparam logic [5:0] BITS_20  = 6'h14;
  localparam logic [5:0] BITS_24  = 6'h18;

  // ==========================================================================
  // Register layouts, most significant field first
  // ==========================================================================
  typedef struct packed {
    logic [6:0] addr;
    logic [8:0] data;
  } ctrl_word_t;

  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic       zc_timeout_disable;
    logic [2:0] rsvd_lo;
  } zc_word_t;

  typedef struct packed {
    logic      highpass_bypass;
    logic      rsvd;
    logic      master_clock_invert;
    word_len_t word_length_sel;
    logic      bit_clock_invert;
    logic      frame_polarity_or_variant;
    framing_t  framing_format_sel;
  } iface_word_t;

  typedef struct packed {
    logic       clock_role_sel;
    logic [3:0] rsvd;
    logic       oversample_sel;
    logic [2:0] clock_ratio_sel;
  } clocking_word_t;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       input_buffer_powerdown;
    logic [3:0] rsvd_mid;
    logic       converter_powerdown;
    logic       chip_powerdown;
  } power_word_t;

  typedef struct packed {
    logic       zero_cross_en;
    logic [7:0] gain_value;
  } gain_word_t;

  typedef struct packed {
    level_fn_t  level_function_sel;
    logic [2:0] gain_ceiling;
    logic [3:0] level_target;
  } level_one_word_t;

  typedef struct packed {
    logic       level_function_en;
    logic       level_zero_cross_en;
    logic [2:0] rsvd;
    logic [3:0] hold_time;
  } level_two_word_t;

  typedef struct packed {
    logic       rsvd;
    logic [3:0] release_rate;
    logic [3:0] attack_rate;
  } rates_word_t;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [2:0] quiet_gate_threshold;
    logic       rsvd_lo;
    logic       quiet_gate_en;
  } gate_word_t;

  typedef struct packed {
    logic       rsvd;
    logic       fixed_one;
    logic [2:0] transient_window;
    logic [3:0] attenuation_floor;
  } limiter_word_t;

  typedef struct packed {
    logic       stereo_gain_link;
    logic       left_mute;
    logic       right_mute;
    logic [1:0] rsvd;
    logic [3:0] input_pair_select;
  } mux_word_t;

  typedef struct packed {
    zc_word_t        zc_timeout;
    iface_word_t     audio_interface;
    clocking_word_t  master_clocking;
    power_word_t     power_down;
    gain_word_t      left_gain;
    gain_word_t      right_gain;
    level_one_word_t level_one;
    level_two_word_t level_two;
    rates_word_t     level_rates;
    gate_word_t      quiet_gate;
    limiter_word_t   limiter_window;
    mux_word_t       input_select;
  } settings_t;

  localparam settings_t SETTINGS_RESET = '{
    zc_timeout:      zc_word_t'(ZC_TIMEOUT_RESET),
    audio_interface: iface_word_t'(AUDIO_INTERFACE_RESET),
    master_clocking: clocking_word_t'(MASTER_CLOCKING_RESET),
    power_down:      power_word_t'(POWER_DOWN_RESET),
    left_gain:       gain_word_t'(GAIN_RESET),
    right_gain:      gain_word_t'(GAIN_RESET),
    level_one:       level_one_word_t'(LEVEL_ONE_RESET),
    level_two:       level_two_word_t'(LEVEL_TWO_RESET),
    level_rates:     rates_word_t'(LEVEL_RATES_RESET),
    quiet_gate:      gate_word_t'(QUIET_GATE_RESET),
    limiter_window:  limiter_word_t'(LIMITER_WINDOW_RESET),
    input_select:    mux_word_t'(INPUT_SELECT_RESET)
  };

  typedef struct packed {
    logic       frame_clock_oe_n;
    logic       bit_clock_oe_n;
    logic       frame_clock_inverted;
    logic       dsp_variant_b;
    logic       data_launch_rising;
    logic       master_clock_inverted;
    logic       highpass_active;
    logic       zc_timeout_active;
    logic       chip_active;
    logic       converter_active;
    logic       input_buffer_active;
    logic [3:0] active_pairs;
    logic       level_left_active;
    logic       level_right_active;
    logic [9:0] mclk_per_frame;
    logic [7:0] oversample_ratio;
    logic [5:0] sample_bits;
    logic [8:0] left_gain_half_db;
    logic [8:0] right_gain_half_db;
  } derived_t;

endpackage : audio_adc_ctrl_pkg

/* logic/audio_adc_control_registers.sv */
// Control register bank of a stereo audio converter, loaded by control words
`timescale 1ns/10ps
// Operation
// - Word is 16 bits: seven address bits above nine data bits.
// - Zero-cross timeout: bit 3 of 07h, 0 active, 1 disabled, reset 0.
// - Framing format: 00 right, 01 left, 10 I2S, 11 DSP; reset 10.
// - Interface bit 2: frame clock invert, or DSP variant A/B.
// - Interface bit 3: bit clock polarity; at 0 data changes falling edge.
// - Word length bits 5:4: 00 16, 01 20, 10 24 bits; reset 10.
// - Interface bit 6 inverts the master clock when set.
// - Interface bit 8 bypasses the high-pass filter when set.
// - Master clock per frame: 010 256, 011 384, 100 512, 101 768.
// - Master-mode bit 3: 0 gives 128x, 1 gives 64x oversampling.
// - Master-mode bit 8: 0 slave clocks in, 1 device drives both clocks.
// - Power-down bit 0 puts the whole chip into power save.
// - Power-down bit 1 powers down only the converter.
// - Power-down bit 6 powers down input multiplexer and buffer.
// - Register 14h: fixed one bit 7, window 6:4, attenuation 3:0, reset 0A6.
// - Any write to 17h restores all defaults; written data is dropped.
// - Eight-bit channel gain in half-decibel steps, reset value is 0dB.
// - Level function: 00 limiter, 01 right, 10 left, 11 both channels.
// - Four input-select bits each add one stereo pair; reset pair one.

module audio_adc_control_registers (
  input  wire logic                           clock,
  input  wire logic                           rstn,
  input  wire logic                           word_valid,
  input  wire audio_adc_ctrl_pkg::ctrl_word_t word,
  output audio_adc_ctrl_pkg::settings_t       settings,
  output audio_adc_ctrl_pkg::derived_t        derived,
  output logic                                soft_reset_pulse
);

  audio_adc_ctrl_pkg::settings_t settings_q;
  audio_adc_ctrl_pkg::settings_t settings_d;
  audio_adc_ctrl_pkg::derived_t  derived_q;
  audio_adc_ctrl_pkg::derived_t  derived_d;
  logic                          soft_reset_q;
  logic                          soft_reset_d;

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Each register except 14h, whose bit 7 is forced to one, takes the nine data bits whole; undefined bits are held as
  // written, so a host that leaves them nonzero sees no side effect.
  always_comb
  begin
    settings_d   = settings_q;
    soft_reset_d = 1'b0;
    if (word_valid)
    begin
      case (word.addr)
        audio_adc_ctrl_pkg::ZC_TIMEOUT_ADDR:
          settings_d.zc_timeout = audio_adc_ctrl_pkg::zc_word_t'(word.data);
        audio_adc_ctrl_pkg::AUDIO_INTERFACE_ADDR:
          settings_d.audio_interface = audio_adc_ctrl_pkg::iface_word_t'(word.data);
        audio_adc_ctrl_pkg::MASTER_CLOCKING_ADDR:
          settings_d.master_clocking = audio_adc_ctrl_pkg::clocking_word_t'(word.data);
        audio_adc_ctrl_pkg::POWER_DOWN_ADDR:
          settings_d.power_down = audio_adc_ctrl_pkg::power_word_t'(word.data);
        audio_adc_ctrl_pkg::LEFT_GAIN_ADDR:
          settings_d.left_gain = audio_adc_ctrl_pkg::gain_word_t'(word.data);
        audio_adc_ctrl_pkg::RIGHT_GAIN_ADDR:
          settings_d.right_gain = audio_adc_ctrl_pkg::gain_word_t'(word.data);
        audio_adc_ctrl_pkg::LEVEL_ONE_ADDR:
          settings_d.level_one = audio_adc_ctrl_pkg::level_one_word_t'(word.data);
        audio_adc_ctrl_pkg::LEVEL_TWO_ADDR:
          settings_d.level_two = audio_adc_ctrl_pkg::level_two_word_t'(word.data);
        audio_adc_ctrl_pkg::LEVEL_RATES_ADDR:
          settings_d.level_rates = audio_adc_ctrl_pkg::rates_word_t'(word.data);
        audio_adc_ctrl_pkg::QUIET_GATE_ADDR:
          settings_d.quiet_gate = audio_adc_ctrl_pkg::gate_word_t'(word.data);
        audio_adc_ctrl_pkg::LIMITER_WINDOW_ADDR:
        begin
          settings_d.limiter_window = audio_adc_ctrl_pkg::limiter_word_t'(word.data);
          settings_d.limiter_window.fixed_one = 1'b1;
        end
        audio_adc_ctrl_pkg::INPUT_SELECT_ADDR:
          settings_d.input_select = audio_adc_ctrl_pkg::mux_word_t'(word.data);
        audio_adc_ctrl_pkg::SOFTWARE_RESET_ADDR:
        begin
          settings_d   = audio_adc_ctrl_pkg::SETTINGS_RESET;
          soft_reset_d = 1'b1;
        end
        // Unmapped addresses are dropped silently
        default:
          settings_d = settings_q;
      endcase
    end
  end

  // ==========================================================================
  // Decoded controls
  // ==========================================================================
  // Decoded from the next settings so both outputs change on the same edge.
  always_comb
  begin
    derived_d = '0;
    // Master drives frame and bit clocks; enables are active low
    derived_d.frame_clock_oe_n = ~settings_d.master_clocking.clock_role_sel;
    derived_d.bit_clock_oe_n   = ~settings_d.master_clocking.clock_role_sel;
    if (settings_d.audio_interface.framing_format_sel == audio_adc_ctrl_pkg::FMT_DSP)
      derived_d.dsp_variant_b = settings_d.audio_interface.frame_polarity_or_variant;
    else
      derived_d.frame_clock_inverted =
        settings_d.audio_interface.frame_polarity_or_variant;
    derived_d.data_launch_rising    = settings_d.audio_interface.bit_clock_invert;
    derived_d.master_clock_inverted = settings_d.audio_interface.master_clock_invert;
    derived_d.highpass_active       = ~settings_d.audio_interface.highpass_bypass;
    derived_d.zc_timeout_active     = ~settings_d.zc_timeout.zc_timeout_disable;
    derived_d.chip_active           = ~settings_d.power_down.chip_powerdown;
    derived_d.converter_active      = ~settings_d.power_down.chip_powerdown
                                    & ~settings_d.power_down.converter_powerdown;
    derived_d.input_buffer_active   = ~settings_d.power_down.chip_powerdown
                                    & ~settings_d.power_down.input_buffer_powerdown;
    // With the buffer down every pair is switched off the converter input
    derived_d.active_pairs = derived_d.input_buffer_active
                           ? settings_d.input_select.input_pair_select : 4'h0;
    case (settings_d.level_one.level_function_sel)
      audio_adc_ctrl_pkg::LF_RIGHT:
        derived_d.level_right_active = 1'b1;
      audio_adc_ctrl_pkg::LF_LEFT:
        derived_d.level_left_active = 1'b1;
      default:
      begin
        derived_d.level_left_active  = 1'b1;
        derived_d.level_right_active = 1'b1;
      end
    endcase
    case (settings_d.master_clocking.clock_ratio_sel)
      audio_adc_ctrl_pkg::RATE_256: derived_d.mclk_per_frame = audio_adc_ctrl_pkg::MCLK_256;
      audio_adc_ctrl_pkg::RATE_384: derived_d.mclk_per_frame = audio_adc_ctrl_pkg::MCLK_384;
      audio_adc_ctrl_pkg::RATE_512: derived_d.mclk_per_frame = audio_adc_ctrl_pkg::MCLK_512;
      audio_adc_ctrl_pkg::RATE_768: derived_d.mclk_per_frame = audio_adc_ctrl_pkg::MCLK_768;
      // Undefined ratio codes report zero rather than guess a rate
      default:                      derived_d.mclk_per_frame = 10'h000;
    endcase
    derived_d.oversample_ratio = settings_d.master_clocking.oversample_sel
                               ? audio_adc_ctrl_pkg::OSR_64
                               : audio_adc_ctrl_pkg::OSR_128;
    case (settings_d.audio_interface.word_length_sel)
      audio_adc_ctrl_pkg::WL_16: derived_d.sample_bits = audio_adc_ctrl_pkg::BITS_16;
      audio_adc_ctrl_pkg::WL_20: derived_d.sample_bits = audio_adc_ctrl_pkg::BITS_20;
      // The reserved code falls back to the widest defined length
      default:                   derived_d.sample_bits = audio_adc_ctrl_pkg::BITS_24;
    endcase
    // Signed offset from the 0dB code, one count per half decibel
    derived_d.left_gain_half_db  = {1'b0, settings_d.left_gain.gain_value}
                                 - {1'b0, audio_adc_ctrl_pkg::GAIN_ZERO_DB};
    derived_d.right_gain_half_db = {1'b0, settings_d.right_gain.gain_value}
                                 - {1'b0, audio_adc_ctrl_pkg::GAIN_ZERO_DB};
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      settings_q   <= audio_adc_ctrl_pkg::SETTINGS_RESET;
      derived_q    <= '{frame_clock_oe_n:   1'b1,
                        bit_clock_oe_n:     1'b1,
                        highpass_active:    1'b1,
                        zc_timeout_active:  1'b1,
                        chip_active:        1'b1,
                        converter_active:   1'b1,
                        input_buffer_active: 1'b1,
                        active_pairs:       4'h1,
                        level_left_active:  1'b1,
                        level_right_active: 1'b1,
                        mclk_per_frame:     audio_adc_ctrl_pkg::MCLK_256,
                        oversample_ratio:   audio_adc_ctrl_pkg::OSR_128,
                        sample_bits:        audio_adc_ctrl_pkg::BITS_24,
                        default:            '0};
      soft_reset_q <= 1'b0;
    end
    else
    begin
      settings_q   <= settings_d;
      derived_q    <= derived_d;
      soft_reset_q <= soft_reset_d;
    end
  end

  assign settings         = settings_q;
  assign derived          = derived_q;
  assign soft_reset_pulse = soft_reset_q;

endmodule : audio_adc_control_registers

/* testbench/audio_ctrl_host.sv */
// Host model: issues 16-bit control words to the register bank
`timescale 1ns/10ps
module audio_ctrl_host (
  input  wire logic                      clock,
  output audio_adc_ctrl_pkg::ctrl_word_t word,
  output logic                           word_valid
);
  // ==========================================================================
  // Word issue
  initial
  begin
    word_valid = 1'h0;
    word       = 16'h0000;
  end

  // Caller arrives just after a rising edge; one word per cycle
  task automatic send(input logic [6:0] a, input logic [8:0] d);
    word_valid <= 1'h1;
    word       <= {a, d};
    @(posedge clock);
  endtask : send

  // Released word shows the inverse, so a stale word never looks fresh
  task automatic idle;
    word_valid <= 1'h0;
    word       <= audio_adc_ctrl_pkg::ctrl_word_t'(~word);
    @(posedge clock);
  endtask : idle
endmodule : audio_ctrl_host

/* testbench/audio_adc_regs_chk.sv */
// Checker: load timing and decode relations of the control register bank
`timescale 1ns/10ps
module audio_adc_regs_chk (
  input wire logic                           clock,
  input wire logic                           rstn,
  input wire logic                           word_valid,
  input wire audio_adc_ctrl_pkg::ctrl_word_t word,
  input wire audio_adc_ctrl_pkg::settings_t  settings,
  input wire audio_adc_ctrl_pkg::derived_t   derived,
  input wire logic                           soft_reset_pulse
);
  // ==========================================================================
  // Assertions
  wire                                  soft_w = word_valid && word.addr == 7'h17;
  wire                                  hole_w = word_valid &&
                                          !(word.addr inside {7'h07, [7'h0B:7'h15], 7'h17});
  wire [1:0]                            fmt    = settings.audio_interface.framing_format_sel;
  wire                                  pol    = settings.audio_interface.frame_polarity_or_variant;
  wire [1:0]                            wl     = settings.audio_interface.word_length_sel;
  wire [2:0]                            rate   = settings.master_clocking.clock_ratio_sel;
  wire audio_adc_ctrl_pkg::power_word_t pd     = settings.power_down;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_iface_load:
    assert property (word_valid && word.addr == 7'h0B |=>
      settings.audio_interface == $past(word.data))
    else $error("interface register did not load the word");
  a_soft_reset_load:
    assert property (soft_w |=> settings == audio_adc_ctrl_pkg::SETTINGS_RESET && soft_reset_pulse)
    else $error("soft reset did not restore defaults");
  a_pulse_cause:
    assert property (soft_reset_pulse == $past(soft_w))
    else $error("soft reset pulse does not follow reset words");
  a_level_sel:
    assert property ({derived.level_left_active, derived.level_right_active} ==
      (settings.level_one.level_function_sel == 2'h0 ? 2'h3 :
       2'(settings.level_one.level_function_sel)))
    else $error("level function decode wrong");
  a_hole_ignored:
    assert property (hole_w |=> $stable(settings))
    else $error("unmapped word changed settings");
  a_zc_timeout:
    assert property (derived.zc_timeout_active == !settings.zc_timeout.zc_timeout_disable)
    else $error("zero-cross timeout decode wrong");
  a_frame_variant:
    assert property (derived.frame_clock_inverted == (fmt != 2'h3 && pol) &&
      derived.dsp_variant_b == (fmt == 2'h3 && pol))
    else $error("frame polarity or variant decode wrong");
  a_clock_pols:
    assert property (derived.data_launch_rising == settings.audio_interface.bit_clock_invert &&
      derived.master_clock_inverted == settings.audio_interface.master_clock_invert &&
      derived.highpass_active == !settings.audio_interface.highpass_bypass)
    else $error("polarity or filter decode wrong");
  a_word_bits:
    assert property (derived.sample_bits == (wl == 2'h0 ? 6'h10 : wl == 2'h1 ? 6'h14 : 6'h18))
    else $error("sample length decode wrong");
  a_clock_ratio:
    assert property (derived.mclk_per_frame == (rate == 3'h2 ? 10'h100 : rate == 3'h3 ? 10'h180 :
      rate == 3'h4 ? 10'h200 : rate == 3'h5 ? 10'h300 : 10'h000))
    else $error("clock ratio decode wrong");
  a_osr_role:
    assert property (derived.oversample_ratio ==
      (settings.master_clocking.oversample_sel ? 8'h40 : 8'h80) &&
      derived.bit_clock_oe_n == !settings.master_clocking.clock_role_sel &&
      derived.frame_clock_oe_n == !settings.master_clocking.clock_role_sel)
    else $error("oversample or clock role decode wrong");
  a_power_tree:
    assert property (derived.chip_active == !pd.chip_powerdown &&
      derived.converter_active == !(pd.chip_powerdown || pd.converter_powerdown) &&
      derived.input_buffer_active == !(pd.chip_powerdown || pd.input_buffer_powerdown))
    else $error("power-down decode wrong");
  a_input_pairs:
    assert property (derived.active_pairs ==
      (derived.input_buffer_active ? settings.input_select.input_pair_select : 4'h0))
    else $error("input pair decode wrong");
  a_limiter_fixed:
    assert property (settings.limiter_window.fixed_one)
    else $error("limiter fixed bit not one");
  a_gain_steps:
    assert property (derived.left_gain_half_db == {1'h0, settings.left_gain.gain_value} - 9'h0CF &&
      derived.right_gain_half_db == {1'h0, settings.right_gain.gain_value} - 9'h0CF)
    else $error("gain step decode wrong");
endmodule : audio_adc_regs_chk

bind audio_adc_control_registers audio_adc_regs_chk chk (
  .clock            (clock),
  .rstn             (rstn),
  .word_valid       (word_valid),
  .word             (word),
  .settings         (settings),
  .derived          (derived),
  .soft_reset_pulse (soft_reset_pulse)
);

/* testbench/audio_adc_control_registers_tb.sv */
// Testbench: control words in, register contents checked against a model
`timescale 1ns/10ps
`define CHK(act, exp) \
  begin \
    n_checks++; \
    if ((act) !== (exp)) \
    begin \
      errors++; \
      $display("[FAIL] %0t got %h expected %h", $time, act, exp); \
    end \
  end

module audio_adc_control_registers_tb;
  // ==========================================================================
  // Bench state
  typedef struct packed {
    audio_adc_ctrl_pkg::settings_t s;
    logic                          p;
  } note_t;

  logic                           clock    = 1'h0;
  logic                           rstn     = 1'h0;
  logic                           seen     = 1'h0;
  audio_adc_ctrl_pkg::ctrl_word_t word;
  logic                           word_valid;
  audio_adc_ctrl_pkg::settings_t  settings;
  audio_adc_ctrl_pkg::settings_t  exp;
  audio_adc_ctrl_pkg::derived_t   derived;
  logic                           soft_reset_pulse;
  note_t                          q[$];
  note_t                          n;
  logic [31:0]                    r;
  int                             errors   = 0;
  int                             n_checks = 0;

  always #2 clock = ~clock;

  audio_ctrl_host host (.clock(clock), .word(word), .word_valid(word_valid));

  audio_adc_control_registers dut (
    .clock            (clock),
    .rstn             (rstn),
    .word_valid       (word_valid),
    .word             (word),
    .settings         (settings),
    .derived          (derived),
    .soft_reset_pulse (soft_reset_pulse)
  );

  task automatic finish_test;
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  // Model update first, then the word goes out
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    case (a)
      7'h07: exp.zc_timeout = d;
      7'h0B: exp.audio_interface = d;
      7'h0C: exp.master_clocking = d;
      7'h0D: exp.power_down = d;
      7'h0E: exp.left_gain = d;
      7'h0F: exp.right_gain = d;
      7'h10: exp.level_one = d;
      7'h11: exp.level_two = d;
      7'h12: exp.level_rates = d;
      7'h13: exp.quiet_gate = d;
      7'h14: exp.limiter_window = d | 9'h080;
      7'h15: exp.input_select = d;
      7'h17: exp = audio_adc_ctrl_pkg::SETTINGS_RESET;
      default: ;
    endcase
    q.push_back({exp, a == 7'h17});
    host.send(a, d);
  endtask : wr

  task automatic drain;
    host.idle();
    for (int i = 0; i < 8 && q.size() != 0; i++)
      @(posedge clock);
    if (q.size() != 0)
    begin
      errors++;
      $display("[FAIL] %0t results missing", $time);
      finish_test();
    end
  endtask : drain

  // ==========================================================================
  // Result watcher: one note per taken word, due one cycle later
  always @(posedge clock)
  begin
    if (seen && rstn)
    begin
      n = q.pop_front();
      `CHK(settings, n.s)
      `CHK(soft_reset_pulse, n.p)
      `CHK({derived.level_left_active, derived.level_right_active}, n.s.level_one.level_function_sel == 2'h0 ? 2'h3 : n.s.level_one.level_function_sel)
    end
    seen = word_valid && rstn;
  end

  initial
  begin
    r   = $urandom(32'h6d595863);
    exp = audio_adc_ctrl_pkg::SETTINGS_RESET;
    repeat (5) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    `CHK(settings, audio_adc_ctrl_pkg::SETTINGS_RESET)
    `CHK(derived.frame_clock_oe_n, 1'h1)
    for (int i = 0; i < 16; i++)
    begin
      r = $urandom;
      wr(7'h0B, {r[2], 1'h0, r[1], i[3:2], r[0], i[2], i[1:0]});
    end
    for (int j = 2; j < 6; j++)
      wr(7'h0C, {j[0], 4'h0, j[1], 3'(j)});
    for (int k = 0; k < 8; k++)
    begin
      r = $urandom;
      wr(7'h0D, {2'h0, k[2], 4'h0, k[1:0]});
      wr(7'h15, {r[8:6], 2'h0, r[3:0]});
    end
    for (int m = 0; m < 4; m++)
    begin
      r = $urandom;
      wr(7'h0E, r[8:0]);
      wr(7'h0F, r[17:9]);
      wr(7'h10, {2'(m), r[26:20]});
    end
    r = $urandom;
    wr(7'h07, {5'h00, r[0], 3'h0});
    wr(7'h11, {r[2:1], 3'h0, r[6:3]});
    wr(7'h12, {1'h0, r[14:7]});
    wr(7'h13, {4'h0, r[17:15], 1'h0, r[18]});
    wr(7'h14, {2'h0, r[25:19]});
    wr(7'h16, r[8:0]);
    wr(7'h00, r[9:1]);
    wr(7'h17, r[10:2]);
    wr(7'h0B, 9'h003);
    drain();
    // Hard reset in mid-run, then a word at the second edge after release
    rstn <= 1'h0;
    @(posedge clock);
    `CHK(settings, audio_adc_ctrl_pkg::SETTINGS_RESET)
    exp = audio_adc_ctrl_pkg::SETTINGS_RESET;
    rstn <= 1'h1;
    @(posedge clock);
    wr(7'h0C, 9'h100);
    drain();
    `CHK(derived.bit_clock_oe_n, 1'h0)
    finish_test();
  end
endmodule : audio_adc_control_registers_tb
